// file: bench/pfd_pid_core_asserts.sv
// Port checker for the PID core.
// Assumes it is bound onto pfd_pid_core.
`timescale 1ns/1ps
module pfd_pid_core_asserts
(
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire logic               sample_stb,
    input wire logic signed [15:0] temp_sample,
    input wire logic signed [15:0] setpoint,
    input wire logic signed [15:0] gain_p,
    input wire logic signed [15:0] gain_i,
    input wire logic signed [15:0] gain_d,
    input wire logic signed [23:0] heater_drive_r,
    input wire logic signed [23:0] proportional_term_r,
    input wire logic signed [23:0] derivative_term_r,
    input wire logic signed [39:0] integral_accumulator_r,
    input wire logic               drive_valid_r
);
    // =========================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic signed [15:0] prev_r;
    // Sample taken by the last update
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            prev_r <= 16'sh0000;
        else if (drive_valid_r)
            prev_r <= $past(temp_sample, 3);
    end
    property p_lat; drive_valid_r |-> $past(sample_stb, 3); endproperty
    a_lat: assert property (p_lat) else $error("result without strobe");
    property p_gap; drive_valid_r |=> !drive_valid_r [*2]; endproperty
    a_gap: assert property (p_gap) else $error("updates too close");
    property p_p; drive_valid_r |-> proportional_term_r == 24'(((longint'($past(setpoint, 3))
        - $past(temp_sample, 3)) * $past(gain_p, 2)) >>> 8); endproperty
    a_p: assert property (p_p) else $error("proportional wrong");
    property p_i; drive_valid_r |-> integral_accumulator_r == 40'($past(integral_accumulator_r)
        + (longint'($past(setpoint, 3)) - $past(temp_sample, 3)) * $past(gain_i, 2)); endproperty
    a_i: assert property (p_i) else $error("accumulator wrong");
    property p_d; drive_valid_r |-> derivative_term_r == 24'(((longint'(prev_r)
        - $past(temp_sample, 3)) * $past(gain_d, 2)) >>> 8); endproperty
    a_d: assert property (p_d) else $error("derivative wrong");
    property p_sum; drive_valid_r |-> heater_drive_r == 24'(proportional_term_r
        + (integral_accumulator_r >>> 8) + derivative_term_r); endproperty
    a_sum: assert property (p_sum) else $error("drive not the sum");
    property p_hold; !drive_valid_r |-> $stable(heater_drive_r) && $stable(integral_accumulator_r); endproperty
    a_hold: assert property (p_hold) else $error("result changed without update");
    property p_rst; $rose(resetn) |-> heater_drive_r == 0 && integral_accumulator_r == 0; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared");
    c_upd: cover property (drive_valid_r);
    c_neg: cover property (drive_valid_r && proportional_term_r < 0);
    c_fall: cover property (drive_valid_r && derivative_term_r > 0);
endmodule
bind pfd_pid_core pfd_pid_core_asserts u_chk (.*);

// file: bench/pfd_pid_core_tb.sv
// Self-checking bench for pfd_pid_core.
// Assumes the sensor model strobes once per cycle of go.
`timescale 1ns/1ps
module pfd_pid_core_tb;
    // =========================================
    // Bench
    logic ref_clk = 1'b0, resetn = 1'b0, go = 1'b0, stb, dv;
    logic signed [15:0] t_in = 0, sp = 0, gp = 0, gi = 0, gd = 0, ts;
    logic signed [23:0] hd, pt, dt;
    logic signed [39:0] ac;
    longint acc = 0, prv = 0;
    int n_mismatch = 0, total_checks = 0;
    // Setpoint, sample, P, I, D gains, then expected P term, accumulator, D term, drive
    logic signed [15:0] rows [5][9] = '{
        '{16'sh0200, 16'sh0100, 16'sh0180, 16'sh0020, 16'sh0040, 16'sh0180, 16'sh2000, 16'shffc0, 16'sh0160},
        '{16'sh0200, 16'sh0200, 16'sh0180, 16'sh0020, 16'sh0040, 16'sh0000, 16'sh2000, 16'shffc0, 16'shffe0},
        '{16'sh0100, 16'sh0300, 16'sh0180, 16'sh0020, 16'sh0040, 16'shfd00, 16'she000, 16'shffc0, 16'shfca0},
        '{16'sh0100, 16'sh0050, 16'sh0180, 16'sh0020, 16'sh0040, 16'sh0108, 16'shf600, 16'sh00ac, 16'sh01aa},
        '{16'shff00, 16'sh0010, 16'sh0100, 16'shffe0, 16'sh0080, 16'shfef0, 16'sh1800, 16'sh0020, 16'shff28}};
    always #10 ref_clk = ~ref_clk;
    pfd_sensor_model SEN (.ref_clk(ref_clk), .go(go), .t_in(t_in), .sample_stb(stb), .temp_sample(ts));
    pfd_pid_core DUT (.ref_clk(ref_clk), .resetn(resetn), .sample_stb(stb), .temp_sample(ts),
        .setpoint(sp), .gain_p(gp), .gain_i(gi), .gain_d(gd), .heater_drive_r(hd),
        .proportional_term_r(pt), .derivative_term_r(dt), .integral_accumulator_r(ac), .drive_valid_r(dv));
    function automatic logic [39:0] w(longint v);
        return 40'($signed(24'(v)));
    endfunction
    task chk(string n, logic [39:0] e, logic [39:0] g);
        total_checks++;
        if (e !== g)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One update; go held n cycles, extra strobes must be ignored
    task upd(input logic signed [15:0] s, t, p, i, d, input int n);
        longint e, ep, ed;
        @(posedge ref_clk);
        #1 {sp, t_in, gp, gi, gd, go} = {s, t, p, i, d, 1'b1};
        repeat (n) @(posedge ref_clk);
        #1 go = 1'b0;
        e = s - t;
        ep = (e * p) >>> 8;
        acc += e * i;
        ed = ((prv - t) * d) >>> 8;
        prv = t;
        repeat (4 - n) @(posedge ref_clk);
        #1 chk("valid", 40'h1, 40'(dv));
        chk("prop", w(ep), 40'(pt));
        chk("acc", 40'(acc), ac);
        chk("deriv", w(ed), 40'(dt));
        chk("drive", w(ep + (acc >>> 8) + ed), 40'(hd));
        repeat (1) @(posedge ref_clk);
        #1 chk("pulse", 40'h0, 40'(dv));
    endtask
    initial
    begin
        #200000 n_mismatch++;
        end_sim();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        #1 resetn = 1'b1;
        for (int r = 0; r < 5; r++)
        begin
            upd(rows[r][0], rows[r][1], rows[r][2], rows[r][3], rows[r][4], 1);
            chk("row_prop", 40'(rows[r][5]), 40'(pt));
            chk("row_acc", 40'(rows[r][6]), ac);
            chk("row_deriv", 40'(rows[r][7]), 40'(dt));
            chk("row_drive", 40'(rows[r][8]), 40'(hd));
        end
        upd(rows[0][0], rows[0][1], rows[0][2], rows[0][3], rows[0][4], 2);
        @(posedge ref_clk);
        #1 resetn = 1'b0;
        #5 chk("rst_acc", 40'h0, ac);
        chk("rst_drive", 40'h0, 40'(hd));
        @(posedge ref_clk);
        #1 resetn = 1'b1;
        acc = 0;
        prv = 0;
        upd(rows[3][0], rows[3][1], rows[3][2], rows[3][3], rows[3][4], 1);
        end_sim();
    end
endmodule

// file: bench/pfd_sensor_model.sv
// Sensor readout model: one strobe per cycle that go is high.
// Assumes go and t_in change just after a rising edge.
`timescale 1ns/1ps
module pfd_sensor_model
(
    input  wire logic               ref_clk,
    input  wire logic               go,
    input  wire logic signed [15:0] t_in,
    output logic                    sample_stb,
    output logic signed [15:0]      temp_sample
);
    // =========================================
    // Readout
    initial sample_stb = 1'b0;
    initial temp_sample = 16'sh0000;
    // Reading is not held between strobes, so show its inverse
    always @(posedge ref_clk)
    begin
        sample_stb <= go;
        temp_sample <= go ? t_in : ~temp_sample;
    end
endmodule

// file: shared/pfd_pkg.sv
// Constants and types for the PID feedback datapath.
// Assumes a single clock domain; samples and gains are signed fixed point.
package pfd_pkg;

    // =========================================================
    // Widths
    localparam int TEMP_W    = 16;
    localparam int GAIN_W    = 16;
    localparam int FRAC_W    = 8;
    localparam int ACC_W     = 40;
    localparam int OUT_W     = 24;

    // =========================================================
    // Reset values
    localparam logic signed [ACC_W-1:0]  ACC_RST  = 40'sh00_0000_0000;
    localparam logic signed [TEMP_W-1:0] PREV_RST = 16'sh0000;

    // =========================================================
    // Pipeline states
    typedef enum logic [2:0]
    {
        PFD_IDLE = 3'b001,
        PFD_MUL  = 3'b010,
        PFD_SUM  = 3'b100
    } pfd_state_type;

endpackage

// file: verilog/pfd_gain_mul.sv
// Signed gain multiplier, registered product.
// Assumes operands held stable while en is pulsed.
`timescale 1ns/1ps
module pfd_gain_mul
#(
    parameter int A_W = 17,
    parameter int G_W = 16
)
(
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    input  wire logic                      en,
    input  wire logic signed [A_W-1:0]     a,
    input  wire logic signed [G_W-1:0]     gain,
    output logic signed [A_W+G_W-1:0]      prod_r
);

    logic signed [A_W+G_W-1:0] prod_nxt;

    always_comb
    begin
        prod_nxt = prod_r;
        if (en)
        begin
            prod_nxt = a * gain;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prod_r <= '0;
        end
        else
        begin
            prod_r <= prod_nxt;
        end
    end

endmodule

// file: verilog/pfd_pid_core.sv
// PID feedback datapath: error, P, I, D and summed heater drive.
// Assumes sample and setpoint come from same-clock logic with a one-cycle strobe.
//
// Function
// - Error equals setpoint minus current measured temperature sample.
// - Proportional term is error times proportional gain; zero for zero error.
// - Integral accumulator adds error times integral gain to its previous value.
// - Derivative term is derivative gain times previous sample minus current sample.
// - Heater drive is sum of the three terms from the same update.
// - One computation for heating and cooling; no sign-dependent path.
`timescale 1ns/1ps
module pfd_pid_core
(
    input  wire logic                                  ref_clk,
    input  wire logic                                  resetn,
    input  wire logic                                  sample_stb,
    input  wire logic signed [pfd_pkg::TEMP_W-1:0]     temp_sample,
    input  wire logic signed [pfd_pkg::TEMP_W-1:0]     setpoint,
    input  wire logic signed [pfd_pkg::GAIN_W-1:0]     gain_p,
    input  wire logic signed [pfd_pkg::GAIN_W-1:0]     gain_i,
    input  wire logic signed [pfd_pkg::GAIN_W-1:0]     gain_d,
    output logic signed [pfd_pkg::OUT_W-1:0]           heater_drive_r,
    output logic signed [pfd_pkg::OUT_W-1:0]           proportional_term_r,
    output logic signed [pfd_pkg::OUT_W-1:0]           derivative_term_r,
    output logic signed [pfd_pkg::ACC_W-1:0]           integral_accumulator_r,
    output logic                                       drive_valid_r
);

    localparam int DW = pfd_pkg::TEMP_W + 1;
    localparam int PW = DW + pfd_pkg::GAIN_W;
    localparam int TW = pfd_pkg::OUT_W;

    // =========================================================
    // State and operands
    pfd_pkg::pfd_state_type         state_r;
    pfd_pkg::pfd_state_type         state_nxt;
    logic signed [DW-1:0]           err_r;
    logic signed [DW-1:0]           err_nxt;
    logic signed [DW-1:0]           dtemp_r;
    logic signed [DW-1:0]           dtemp_nxt;
    logic signed [pfd_pkg::TEMP_W-1:0] prev_r;
    logic signed [pfd_pkg::TEMP_W-1:0] prev_nxt;
    logic signed [pfd_pkg::ACC_W-1:0]  acc_nxt;
    logic signed [TW-1:0]           p_nxt;
    logic signed [TW-1:0]           d_nxt;
    logic signed [TW-1:0]           drive_nxt;
    logic                           valid_nxt;
    logic                           mul_en;
    logic signed [PW-1:0]           p_prod;
    logic signed [PW-1:0]           i_prod;
    logic signed [PW-1:0]           d_prod;
    logic signed [TW-1:0]           i_scaled;

    logic                           take_en;
    logic                           sum_en;

    assign mul_en = (state_r == pfd_pkg::PFD_MUL);
    // Capture only when idle; a strobe during an update is lost, not queued
    assign take_en = (state_r == pfd_pkg::PFD_IDLE) && sample_stb;
    assign sum_en  = (state_r == pfd_pkg::PFD_SUM);

    // =========================================================
    // Gain multipliers, shared structure for all three terms
    pfd_gain_mul #(.A_W(DW), .G_W(pfd_pkg::GAIN_W)) u_mul_p
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .en      (mul_en),
        .a       (err_r),
        .gain    (gain_p),
        .prod_r  (p_prod)
    );

    pfd_gain_mul #(.A_W(DW), .G_W(pfd_pkg::GAIN_W)) u_mul_i
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .en      (mul_en),
        .a       (err_r),
        .gain    (gain_i),
        .prod_r  (i_prod)
    );

    pfd_gain_mul #(.A_W(DW), .G_W(pfd_pkg::GAIN_W)) u_mul_d
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .en      (mul_en),
        .a       (dtemp_r),
        .gain    (gain_d),
        .prod_r  (d_prod)
    );

    // =========================================================
    // Sequencer: idle, multiply, sum
    always_comb
    begin
        state_nxt = state_r;
        valid_nxt = 1'b0;
        case (state_r)
            pfd_pkg::PFD_IDLE:
            begin
                // Strobes arriving while busy are ignored, one update per sample
                // single update
                if (sample_stb)
                begin
                    state_nxt = pfd_pkg::PFD_MUL;
                end
            end
            pfd_pkg::PFD_MUL:
            begin
                state_nxt = pfd_pkg::PFD_SUM;
            end
            pfd_pkg::PFD_SUM:
            begin
                valid_nxt = 1'b1;
                state_nxt = pfd_pkg::PFD_IDLE;
            end
            default:
            begin
                state_nxt = pfd_pkg::PFD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r       <= pfd_pkg::PFD_IDLE;
            drive_valid_r <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            drive_valid_r <= valid_nxt;
        end
    end

    // =========================================================
    // Operand capture on the taken strobe
    // Differences are one bit wider than a sample so they never wrap
    always_comb
    begin
        err_nxt   = err_r;
        dtemp_nxt = dtemp_r;
        prev_nxt  = prev_r;
        if (take_en)
        begin
            err_nxt   = DW'(setpoint) - DW'(temp_sample);
            dtemp_nxt = DW'(prev_r) - DW'(temp_sample);
            prev_nxt  = temp_sample;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            err_r   <= '0;
            dtemp_r <= '0;
            prev_r  <= pfd_pkg::PREV_RST;
        end
        else
        begin
            err_r   <= err_nxt;
            dtemp_r <= dtemp_nxt;
            prev_r  <= prev_nxt;
        end
    end

    // =========================================================
    // Result terms, rewritten only in the sum step
    // No saturation: terms wrap, so gains must keep products in range
    always_comb
    begin
        acc_nxt   = integral_accumulator_r;
        p_nxt     = proportional_term_r;
        d_nxt     = derivative_term_r;
        drive_nxt = heater_drive_r;
        i_scaled  = TW'(integral_accumulator_r >>> pfd_pkg::FRAC_W);
        if (sum_en)
        begin
            // proportional term, truncated to fraction bits
            p_nxt     = TW'(p_prod >>> pfd_pkg::FRAC_W);
            acc_nxt   = integral_accumulator_r + pfd_pkg::ACC_W'(i_prod);
            d_nxt     = TW'(d_prod >>> pfd_pkg::FRAC_W);
            i_scaled  = TW'(acc_nxt >>> pfd_pkg::FRAC_W);
            drive_nxt = p_nxt + i_scaled + d_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            integral_accumulator_r <= pfd_pkg::ACC_RST;
            proportional_term_r    <= '0;
            derivative_term_r      <= '0;
            heater_drive_r         <= '0;
        end
        else
        begin
            integral_accumulator_r <= acc_nxt;
            proportional_term_r    <= p_nxt;
            derivative_term_r      <= d_nxt;
            heater_drive_r         <= drive_nxt;
        end
    end

endmodule
